// ### hdl/pdr_pkg.sv
// Constants, types and address decode shared by the PHY diagnostic register bank
package pdr_pkg;

	// Bus widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// Register indices as printed; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_CABLE_TEST = 12'h124;
	localparam logic [ADDR_W-1:0] IDX_LINK_STATUS = 12'h126;
	localparam logic [ADDR_W-1:0] IDX_SYM_ERR_CNT = 12'h12A;
	localparam logic [ADDR_W-1:0] IDX_IRQ = 12'h136;
	localparam logic [ADDR_W+1:0] ADDR_CABLE_TEST = {IDX_CABLE_TEST, 2'h0};
	localparam logic [ADDR_W+1:0] ADDR_LINK_STATUS = {IDX_LINK_STATUS, 2'h0};
	localparam logic [ADDR_W+1:0] ADDR_SYM_ERR_CNT = {IDX_SYM_ERR_CNT, 2'h0};
	localparam logic [ADDR_W+1:0] ADDR_IRQ = {IDX_IRQ, 2'h0};
	localparam int BADDR_W = ADDR_W + 2;

	// Cable test control field positions
	localparam int CT_START_BIT = 15;
	localparam int CT_RSV_HI_BIT = 14;
	localparam int CT_PAIR_LSB = 12;
	localparam int CT_RSV_LO_LSB = 10;
	localparam int CT_RES_LSB = 8;

	// Cable test encodings and resets
	localparam logic [1:0] PAIR_RST = 2'h0;
	localparam logic [1:0] RES_NO_FAULT = 2'h0;
	localparam logic [1:0] RES_OPEN = 2'h1;
	localparam logic [1:0] RES_SHORT = 2'h2;
	localparam logic [1:0] RES_RSV = 2'h3;
	localparam logic [2:0] CT_RSV_RST = 3'h0;

	// Link status bit positions
	localparam int LINK_1000_BIT = 1;
	localparam int LINK_100_BIT = 0;

	// Counter and interrupt layout
	localparam logic [REG_W-1:0] CNT_RST = 16'h0000;
	localparam logic [REG_W-1:0] CNT_MAX = 16'hFFFF;
	localparam int IRQ_EN_LSB = 8;
	localparam int IRQ_N = 8;
	localparam logic [IRQ_N-1:0] IRQ_EN_RST = 8'h00;
	localparam logic [IRQ_N-1:0] IRQ_ST_RST = 8'h00;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register selector
	typedef enum logic [2:0] {SEL_NONE, SEL_CT, SEL_LINK, SEL_CNT, SEL_IRQ} pdr_sel_e;

	// Decode a byte address into a register selector
	function automatic pdr_sel_e reg_sel(input logic [BADDR_W-1:0] addr);
		if (addr == ADDR_CABLE_TEST) begin
			return SEL_CT;
		end else if (addr == ADDR_LINK_STATUS) begin
			return SEL_LINK;
		end else if (addr == ADDR_SYM_ERR_CNT) begin
			return SEL_CNT;
		end else if (addr == ADDR_IRQ) begin
			return SEL_IRQ;
		end else begin
			return SEL_NONE;
		end
	endfunction

endpackage

// ### hdl/pdr_axil_slave.sv
// AXI4-Lite slave front end turning bus beats into single-cycle register strobes
`timescale 1ns/1ps
module pdr_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pdr_pkg::BADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [pdr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [pdr_pkg::BADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [pdr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic wr_en,
	output logic [pdr_pkg::BADDR_W-1:0] wr_addr,
	output logic [pdr_pkg::DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_en,
	output logic [pdr_pkg::BADDR_W-1:0] rd_addr,
	input wire logic [pdr_pkg::DATA_W-1:0] rd_data,
	input wire logic rd_err
);
	import pdr_pkg::*;

	logic aw_have_r; // Write address captured
	logic w_have_r; // Write data captured
	logic bvalid_r; // Write response pending
	logic rvalid_r; // Read response pending
	logic [BADDR_W-1:0] aw_addr_r; // Held write address
	logic [DATA_W-1:0] w_data_r; // Held write data
	logic [3:0] w_strb_r; // Held byte enables
	logic [1:0] bresp_r; // Held write response
	logic [DATA_W-1:0] rdata_r; // Held read data
	logic [1:0] rresp_r; // Held read response

	////////////////////////////////////////////////////////////////////////////
	// Handshakes: each channel stalls while its beat is held
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign wr_en = aw_have_r && w_have_r && !bvalid_r;
	assign wr_addr = aw_addr_r;
	assign wr_data = w_data_r;
	assign wr_strb = w_strb_r;
	assign rd_en = s_axi_arvalid && !rvalid_r;
	assign rd_addr = s_axi_araddr;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	////////////////////////////////////////////////////////////////////////////
	// Write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_en) begin
			aw_have_r <= 1'b0;
		end
	end

	// Write data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_en) begin
			w_have_r <= 1'b0;
		end
	end

	// Write response after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (wr_en) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read response, data sampled at the accepting edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (rd_en) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule

// ### hdl/pdr_cable_test.sv
// Cable diagnostic launcher: start, busy tracking, pair select and result capture
`timescale 1ns/1ps
module pdr_cable_test (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ctl_wr,
	input wire logic [pdr_pkg::REG_W-1:0] ctl_data,
	input wire logic test_done,
	input wire logic [1:0] test_fault,
	output logic busy,
	output logic [1:0] pair,
	output logic [1:0] result,
	output logic [2:0] rsv_bits,
	output logic test_start,
	output logic test_abort
);
	import pdr_pkg::*;

	typedef enum {PDR_CT_IDLE, PDR_CT_RUN} pdr_ct_e;

	pdr_ct_e state_r; // Launcher state
	logic [1:0] pair_r; // Selected pair
	logic [1:0] result_r; // Last test result
	logic [2:0] rsv_r; // Reserved writable bits
	logic start_r; // Start pulse to the engine
	logic abort_r; // Abort pulse to the engine

	assign busy = (state_r == PDR_CT_RUN);
	assign pair = pair_r;
	assign result = result_r;
	assign rsv_bits = rsv_r;
	assign test_start = start_r;
	assign test_abort = abort_r;

	////////////////////////////////////////////////////////////////////////////
	// Launch, self-clear on completion, abort on write of zero
	always_ff @(posedge aclk) begin
		start_r <= 1'b0;
		abort_r <= 1'b0;
		if (!aresetn) begin
			state_r <= PDR_CT_IDLE;
		end else begin
			case (state_r)
				PDR_CT_IDLE: begin
					if (ctl_wr && ctl_data[CT_START_BIT]) begin
						state_r <= PDR_CT_RUN;
						start_r <= 1'b1;
					end
				end
				PDR_CT_RUN: begin
					if (test_done) begin
						state_r <= PDR_CT_IDLE;
					end else if (ctl_wr && !ctl_data[CT_START_BIT]) begin
						state_r <= PDR_CT_IDLE;
						abort_r <= 1'b1;
					end
				end
				default: begin
					state_r <= PDR_CT_IDLE;
				end
			endcase
		end
	end

	// Pair select and reserved storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pair_r <= PAIR_RST;
			rsv_r <= CT_RSV_RST;
		end else if (ctl_wr) begin
			pair_r <= ctl_data[CT_PAIR_LSB +: 2];
			rsv_r <= {ctl_data[CT_RSV_HI_BIT], ctl_data[CT_RSV_LO_LSB +: 2]};
		end
	end

	// Result capture; the reserved code is never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_r <= RES_NO_FAULT;
		end else if (busy && test_done) begin
			result_r <= (test_fault == RES_RSV) ? RES_NO_FAULT : test_fault;
		end
	end

endmodule

// ### hdl/pdr_regs.sv
// Per-port PHY diagnostic, link status, symbol error counter and interrupt registers
`timescale 1ns/1ps
module pdr_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pdr_pkg::BADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [pdr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [pdr_pkg::BADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [pdr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic cable_test_start,
	output logic cable_test_abort,
	output logic [1:0] cable_test_pair,
	input wire logic cable_test_done,
	input wire logic [1:0] cable_test_fault,
	input wire logic link_up_1000,
	input wire logic link_up_100,
	input wire logic rx_symbol_error_frame,
	input wire logic evt_jabber,
	input wire logic evt_rx_error,
	input wire logic evt_page_rx,
	input wire logic evt_pd_fault,
	input wire logic evt_lp_ack,
	input wire logic evt_link_down,
	input wire logic evt_remote_fault,
	input wire logic evt_link_up,
	output logic port_irq
);
	import pdr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic wr_en; // Write strobe from bus
	logic [BADDR_W-1:0] wr_addr; // Write byte address
	logic [DATA_W-1:0] wr_data; // Write data
	logic [3:0] wr_strb; // Write byte enables
	logic wr_err; // Unmapped write
	logic rd_en; // Read strobe from bus
	logic [BADDR_W-1:0] rd_addr; // Read byte address
	logic [DATA_W-1:0] rd_data; // Read data to bus
	logic rd_err; // Unmapped read
	pdr_sel_e wr_sel; // Write target
	pdr_sel_e rd_sel; // Read target
	logic [REG_W-1:0] wr_word; // Merged low half for byte lanes
	logic ct_wr; // Cable test register write
	logic ct_busy; // Test in progress
	logic [1:0] ct_result; // Test result
	logic [2:0] ct_rsv; // Reserved writable bits
	logic [REG_W-1:0] ct_word; // Cable test readback
	logic [REG_W-1:0] cnt_r; // Symbol error frame count
	logic [REG_W-1:0] cnt_nxt; // Next count
	logic [IRQ_N-1:0] irq_en_r; // Interrupt enables
	logic [IRQ_N-1:0] irq_st_r; // Interrupt status
	logic [IRQ_N-1:0] irq_st_nxt; // Next status
	logic [IRQ_N-1:0] evt_vec; // Events in status bit order
	logic [REG_W-1:0] rd_word; // Selected register value

	////////////////////////////////////////////////////////////////////////////
	// Bus front end
	pdr_axil_slave i_pdr_axil_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decode and byte lane merge
	assign wr_sel = reg_sel(wr_addr);
	assign rd_sel = reg_sel(rd_addr);
	assign wr_err = (wr_sel == SEL_NONE);
	assign rd_err = (rd_sel == SEL_NONE);
	assign ct_word = {ct_busy, ct_rsv[2], cable_test_pair, ct_rsv[1:0], ct_result, 8'h00};
	// Lanes not enabled keep the current contents
	assign wr_word[7:0] = wr_strb[0] ? wr_data[7:0] : ct_word[7:0];
	assign wr_word[15:8] = wr_strb[1] ? wr_data[15:8] : ct_word[15:8];
	assign ct_wr = wr_en && (wr_sel == SEL_CT) && (wr_strb[1:0] != 2'h0);

	////////////////////////////////////////////////////////////////////////////
	// Cable diagnostic launcher
	pdr_cable_test i_pdr_cable_test (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl_wr(ct_wr),
		.ctl_data(wr_word),
		.test_done(cable_test_done),
		.test_fault(cable_test_fault),
		.busy(ct_busy),
		.pair(cable_test_pair),
		.result(ct_result),
		.rsv_bits(ct_rsv),
		.test_start(cable_test_start),
		.test_abort(cable_test_abort)
	);

	////////////////////////////////////////////////////////////////////////////
	// Symbol error frame counter; a frame in the read cycle survives the clear
	always_comb begin
		cnt_nxt = cnt_r;
		if (rd_en && (rd_sel == SEL_CNT)) begin
			cnt_nxt = CNT_RST;
		end
		if (rx_symbol_error_frame && (cnt_nxt != CNT_MAX)) begin
			cnt_nxt = cnt_nxt + 16'h0001;
		end
	end

	// Counter register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt events, bit 7 down to bit 0
	assign evt_vec = {evt_jabber, evt_rx_error, evt_page_rx, evt_pd_fault,
		evt_lp_ack, evt_link_down, evt_remote_fault, evt_link_up};

	// Sticky status, clear on read, set wins
	always_comb begin
		irq_st_nxt = irq_st_r;
		if (rd_en && (rd_sel == SEL_IRQ)) begin
			irq_st_nxt = IRQ_ST_RST;
		end
		irq_st_nxt = irq_st_nxt | evt_vec;
	end

	// Status register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_r <= IRQ_ST_RST;
		end else begin
			irq_st_r <= irq_st_nxt;
		end
	end

	// Enable register, high byte lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_r <= IRQ_EN_RST;
		end else if (wr_en && (wr_sel == SEL_IRQ) && wr_strb[1]) begin
			irq_en_r <= wr_data[IRQ_EN_LSB +: IRQ_N];
		end
	end

	// Port interrupt request
	assign port_irq = |(irq_st_r & irq_en_r);

	////////////////////////////////////////////////////////////////////////////
	// Read mux
	always_comb begin
		rd_word = '0;
		case (rd_sel)
			SEL_CT: rd_word = ct_word;
			SEL_LINK: begin
				rd_word[LINK_1000_BIT] = link_up_1000;
				rd_word[LINK_100_BIT] = link_up_100;
			end
			SEL_CNT: rd_word = cnt_r;
			SEL_IRQ: rd_word = {irq_en_r, irq_st_r};
			default: rd_word = '0;
		endcase
	end
	assign rd_data = {16'h0000, rd_word};

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ct_launch;
		ct_wr && wr_word[CT_START_BIT] && !ct_busy |=> ct_busy && cable_test_start;
	endproperty
	a_ct_launch: assert property (p_ct_launch) else $error("test not launched");

	property p_ct_selfclear;
		ct_busy && cable_test_done |=> !ct_busy && !cable_test_start;
	endproperty
	a_ct_selfclear: assert property (p_ct_selfclear) else $error("busy not cleared");

	property p_ct_readback;
		rd_en && (rd_sel == SEL_CT) |=> s_axi_rdata[CT_START_BIT] == $past(ct_busy);
	endproperty
	a_ct_readback: assert property (p_ct_readback) else $error("busy readback wrong");

	property p_ct_disable;
		ct_busy && !cable_test_done && ct_wr && !wr_word[CT_START_BIT] |=> !ct_busy;
	endproperty
	a_ct_disable: assert property (p_ct_disable) else $error("zero write kept test");

	property p_ct_pair;
		ct_wr |=> cable_test_pair == $past(wr_word[CT_PAIR_LSB +: 2]);
	endproperty
	a_ct_pair: assert property (p_ct_pair) else $error("pair not stored");

	property p_ct_result;
		ct_result != RES_RSV;
	endproperty
	a_ct_result: assert property (p_ct_result) else $error("reserved result");

	property p_link;
		rd_en && (rd_sel == SEL_LINK) |=>
			s_axi_rdata == {30'h0, $past(link_up_1000), $past(link_up_100)};
	endproperty
	a_link: assert property (p_link) else $error("link status readback wrong");

	property p_cnt_clear;
		rd_en && (rd_sel == SEL_CNT) && !rx_symbol_error_frame |=> cnt_r == CNT_RST;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");

	property p_cnt_inc;
		rx_symbol_error_frame && !rd_en && (cnt_r != CNT_MAX) |=> cnt_r == $past(cnt_r) + 16'h0001;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("count not advanced");

	property p_en_reset;
		$rose(aresetn) |-> irq_en_r == IRQ_EN_RST && !port_irq;
	endproperty
	a_en_reset: assert property (disable iff (1'b0) p_en_reset) else $error("enable not reset");

	property p_st_set;
		evt_jabber && evt_link_up |=> irq_st_r[7] && irq_st_r[0];
	endproperty
	a_st_set: assert property (p_st_set) else $error("status not set");

	property p_st_set_any;
		(evt_vec != 8'h00) |=> ((irq_st_r & $past(evt_vec)) == $past(evt_vec));
	endproperty
	a_st_set_any: assert property (p_st_set_any) else $error("event lost");

	property p_st_clear;
		rd_en && (rd_sel == SEL_IRQ) && (evt_vec == 8'h00) |=> irq_st_r == IRQ_ST_RST;
	endproperty
	a_st_clear: assert property (p_st_clear) else $error("status not cleared");

	property p_irq;
		((irq_st_r & irq_en_r) != 8'h00) |-> port_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	// Request drops once no enabled status bit remains
	property p_irq_fall;
		((irq_st_r & irq_en_r) == 8'h00) |-> !port_irq;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt stuck");

	property p_irq_quiet;
		(irq_en_r == 8'h00) |-> !port_irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt while masked");

endmodule

// ### test/pdr_regs_tb.sv
// Self-checking bench for the PHY diagnostic register bank
`timescale 1ns/1ps
module pdr_regs_tb;
	import pdr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Stimulus and observation signals
	logic aclk = 1'b0; // 10 MHz bus clock
	logic aresetn = 1'b0; // Synchronous reset, low
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [BADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp, cable_test_pair;
	logic cable_test_start, cable_test_abort, port_irq;
	logic test_done = 1'b0; // Engine completion pulse
	logic [1:0] test_fault = 2'h0; // Engine fault code
	logic link_1000 = 1'b0, link_100 = 1'b0, sym_err = 1'b0;
	logic [7:0] evt = 8'h00; // Event sources, jabber at bit 7 down to link up at bit 0
	int miscompares = 0;
	int check_count = 0;
	int start_cnt = 0;
	int abort_cnt = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and engine pulse counters
	always #50 aclk = ~aclk;
	// Counted mid-cycle so checks at the next rising edge see a settled count
	always @(negedge aclk) begin
		if (aresetn && cable_test_start === 1'b1) start_cnt++;
		if (aresetn && cable_test_abort === 1'b1) abort_cnt++;
	end

	pdr_regs i_pdr_regs (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.cable_test_start(cable_test_start), .cable_test_abort(cable_test_abort),
		.cable_test_pair(cable_test_pair), .cable_test_done(test_done),
		.cable_test_fault(test_fault), .link_up_1000(link_1000), .link_up_100(link_100),
		.rx_symbol_error_frame(sym_err), .evt_jabber(evt[7]), .evt_rx_error(evt[6]),
		.evt_page_rx(evt[5]), .evt_pd_fault(evt[4]), .evt_lp_ack(evt[3]),
		.evt_link_down(evt[2]), .evt_remote_fault(evt[1]), .evt_link_up(evt[0]),
		.port_irq(port_irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	// Compare and count
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask

	// Verdict and end of run
	task automatic finish_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Write one word; ready sampled mid-cycle equals its value at the next edge
	task automatic wr(input logic [BADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ah, wh, done;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			done = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	// Read one word and compare data and response
	task automatic rd(input logic [BADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ah, done;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge aclk);
			ah = arvalid && arready;
			done = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
		chk("rdata", ed, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	// One-cycle engine completion with a fault code
	task automatic engine_done(input logic [1:0] f);
		@(posedge aclk);
		test_done <= 1'b1;
		test_fault <= f;
		@(posedge aclk);
		test_done <= 1'b0;
	endtask

	// One-cycle event pulse, then interrupt line looked at once settled
	task automatic pulse_evt(input logic [7:0] m, input logic eirq);
		@(posedge aclk);
		evt <= m;
		@(posedge aclk);
		evt <= 8'h00;
		@(negedge aclk);
		chk("port_irq", {31'h0, eirq}, {31'h0, port_irq});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	// Reset values of the cable test, counter and interrupt registers
	task automatic t_reset();
		rd(ADDR_CABLE_TEST, 32'h0, RESP_OKAY);
		rd(ADDR_SYM_ERR_CNT, 32'h0, RESP_OKAY);
		rd(ADDR_IRQ, 32'h0, RESP_OKAY);
		chk("irq_rst", 32'h0, {31'h0, port_irq});
	endtask

	// Link state bits follow both inputs
	task automatic t_link();
		logic [1:0] lk;
		for (int k = 0; k < 4; k++) begin
			lk = k[1:0];
			@(posedge aclk);
			link_1000 <= lk[1];
			link_100 <= lk[0];
			rd(ADDR_LINK_STATUS, {30'h0, lk}, RESP_OKAY);
		end
		wr(ADDR_LINK_STATUS, 16'hFFFF, RESP_OKAY);
		rd(ADDR_LINK_STATUS, 32'h3, RESP_OKAY);
	endtask

	// Launch, busy, completion, abort and fault codes
	task automatic t_cable();
		wr(ADDR_CABLE_TEST, 16'hA000, RESP_OKAY);
		chk("start_cnt", 32'd1, start_cnt);
		chk("pair", 32'h2, {30'h0, cable_test_pair});
		rd(ADDR_CABLE_TEST, 32'hA000, RESP_OKAY);
		engine_done(RES_OPEN);
		rd(ADDR_CABLE_TEST, 32'h2100, RESP_OKAY);
		wr(ADDR_CABLE_TEST, 16'hB000, RESP_OKAY);
		chk("pair", 32'h3, {30'h0, cable_test_pair});
		engine_done(RES_SHORT);
		rd(ADDR_CABLE_TEST, 32'h3200, RESP_OKAY);
		wr(ADDR_CABLE_TEST, 16'h8000, RESP_OKAY);
		engine_done(RES_RSV);
		rd(ADDR_CABLE_TEST, 32'h0000, RESP_OKAY);
		wr(ADDR_CABLE_TEST, 16'h9000, RESP_OKAY);
		wr(ADDR_CABLE_TEST, 16'h0000, RESP_OKAY);
		chk("abort_cnt", 32'd1, abort_cnt);
		chk("start_cnt", 32'd4, start_cnt);
		rd(ADDR_CABLE_TEST, 32'h0000, RESP_OKAY);
	endtask

	// Errored frames counted, cleared by reading, not writable
	task automatic t_count();
		@(posedge aclk);
		sym_err <= 1'b1;
		repeat (5) @(posedge aclk);
		sym_err <= 1'b0;
		wr(ADDR_SYM_ERR_CNT, 16'h1234, RESP_OKAY);
		rd(ADDR_SYM_ERR_CNT, 32'd5, RESP_OKAY);
		rd(ADDR_SYM_ERR_CNT, 32'd0, RESP_OKAY);
	endtask

	// Each source latched, masked, enabled and cleared by reading
	task automatic t_irq();
		logic [15:0] en;
		wr(ADDR_IRQ, 16'h00FF, RESP_OKAY);
		rd(ADDR_IRQ, 32'h0, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			pulse_evt(8'h01 << i, 1'b0);
			rd(ADDR_IRQ, 32'h1 << i, RESP_OKAY);
			rd(ADDR_IRQ, 32'h0, RESP_OKAY);
		end
		for (int i = 0; i < 8; i++) begin
			en = 16'h0100 << i;
			wr(ADDR_IRQ, en | 16'h00FF, RESP_OKAY);
			pulse_evt(~(8'h01 << i), 1'b0);
			pulse_evt(8'h01 << i, 1'b1);
			rd(ADDR_IRQ, {16'h0, en | 16'h00FF}, RESP_OKAY);
			@(negedge aclk);
			chk("port_irq_clr", 32'h0, {31'h0, port_irq});
		end
	endtask

	// Unmapped place refused
	task automatic t_unmapped();
		wr(14'h0000, 16'hFFFF, RESP_SLVERR);
		rd(14'h0004, 32'h0, RESP_SLVERR);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_link();
		t_cable();
		t_count();
		t_irq();
		t_unmapped();
		finish_test();
	end

	// Hang cut short well beyond the expected few hundred cycles
	initial begin
		#2000000;
		miscompares++;
		finish_test();
	end
endmodule
